// >>> logic/mes_eeprom_slave.v
`timescale 1ns/1ps
`default_nettype none
`include "mes_regs.vh"
// Notes on behaviour
// [RULE1] Data line changes only while clock low, except start and stop.
// [RULE2] Start is data falling with clock high; nothing answered before it.
// [RULE3] Stop is data rising with clock high and closes every transfer.
// [RULE4] After a stop the slave returns to standby until next start.
// [RULE5] Sender releases data after eight bits; receiver pulls low on ninth.
// [RULE6] Slave acknowledges a select byte carrying its own address.
// [RULE7] Selected for write, slave acknowledges every further received byte; code refuses data while write control high, and array data while protected.
// [RULE8] Read sends eight bits, samples master ack, continues while acked.
// [RULE9] No ack after a sent byte: stop sending and wait for stop.
// [RULE10] Select byte is shifted most significant bit first.
// [RULE11] Array select: identifier 1010, chip select bits, read/write flag.
// [RULE12] Protection select: identifier 0110, same lower four bits.
// [RULE13] Random read: write select, address, restart, read select.
// [RULE14] Current address and sequential reads start with read select.
// [RULE15] Writes need read/write zero, write control low, up to 16 bytes.
// [RULE16] After write stop, program cycle up to 10 ms, bus ignored.
// [RULE17] Ack select only on matching chip select pins and known identifier.
module mes_eeprom_slave
#(
  parameter [19:0] PROG_CYCLES = `MES_PROG_CYCLES
)
(
  input wire clk_sys,
  input wire sys_rst,
  input wire scl_in,
  input wire sda_in,
  input wire chip_select_bit_2,
  input wire chip_select_bit_1,
  input wire chip_select_bit_0,
  input wire write_control_input,
  output reg sda_out_ff,
  output reg sda_oe_ff,
  output reg standby_ff,
  output reg prog_busy_ff,
  output reg write_protect_ff
);
  localparam ST_IDLE = 3'b000;
  localparam ST_SEL = 3'b001;
  localparam ST_ADDR = 3'b010;
  localparam ST_WR = 3'b011;
  localparam ST_RD = 3'b100;
  localparam ST_WAIT = 3'b101;
  localparam ST_PROG = 3'b110;

  // Pin synchronisers
  reg scl_m_ff, scl_s_ff, scl_d_ff;
  reg sda_m_ff, sda_s_ff, sda_d_ff;
  reg [2:0] cs_m_ff, cs_s_ff;
  reg wc_m_ff, wc_s_ff;

  reg [2:0] state_ff, nxt_state;
  reg [2:0] nstate_ff, nxt_nstate;
  reg [3:0] cnt_ff, nxt_cnt;
  reg ack_ph_ff, nxt_ack_ph;
  reg [7:0] shift_ff, nxt_shift;
  reg nxt_oe;
  reg [7:0] addr_ff, nxt_addr;
  reg psel_ff, nxt_psel;
  reg wr_seen_ff, nxt_wr_seen;
  reg nxt_prot;
  reg mack_ff, nxt_mack;
  reg rd_req_ff, nxt_rd_req;
  reg pend_ff, nxt_pend;
  reg [15:0] pend_word_ff, nxt_pend_word;
  reg [19:0] prog_cnt_ff, nxt_prog_cnt;

  // Two-entry write buffer
  reg [15:0] fifo_ff [0:1];
  reg fifo_wp_ff, fifo_rp_ff;
  reg [1:0] fifo_cnt_ff;

  wire scl_rise = scl_s_ff & ~scl_d_ff;
  wire scl_fall = ~scl_s_ff & scl_d_ff;
  wire start_det = scl_s_ff & scl_d_ff & sda_d_ff & ~sda_s_ff; // see [RULE2]
  wire stop_det = scl_s_ff & scl_d_ff & ~sda_d_ff & sda_s_ff; // see [RULE3]
  wire active = (state_ff != ST_IDLE) && (state_ff != ST_PROG);
  wire fifo_ready = (fifo_cnt_ff != `MES_FIFO_FULL);
  wire push = pend_ff & fifo_ready;
  wire pop = (fifo_cnt_ff != `MES_FIFO_EMPTY) & ~rd_req_ff;
  wire [15:0] fifo_head = fifo_ff[fifo_rp_ff];
  wire [7:0] mem_rdata;
  wire [3:0] sel_id = shift_ff[`MES_ID_MSB:`MES_ID_LSB];
  wire [2:0] sel_cs = shift_ff[`MES_CS_MSB:`MES_CS_LSB];
  wire id_mem = (sel_id == `MES_ID_MEM); // see [RULE11]
  wire id_prot = (sel_id == `MES_ID_PROT); // see [RULE12]
  wire sel_match = (sel_cs == cs_s_ff) && (id_mem || id_prot); // see [RULE17]
  wire wr_ok = ~wc_s_ff && (psel_ff || ~write_protect_ff); // see [RULE15]
  wire [7:0] tx_byte = psel_ff ? {`MES_PROT_PAD, write_protect_ff} :
    mem_rdata;

  mes_mem u_mem
  (
    .clk_sys(clk_sys),
    .wr_en(pop),
    .wr_addr(fifo_head[15:8]),
    .wr_data(fifo_head[7:0]),
    .rd_en(rd_req_ff),
    .rd_addr(addr_ff),
    .rd_data_ff(mem_rdata)
  );

  always @*
  begin
    nxt_state = state_ff;
    nxt_nstate = nstate_ff;
    nxt_cnt = cnt_ff;
    nxt_ack_ph = ack_ph_ff;
    nxt_shift = shift_ff;
    nxt_oe = sda_oe_ff;
    nxt_addr = addr_ff;
    nxt_psel = psel_ff;
    nxt_wr_seen = wr_seen_ff;
    nxt_prot = write_protect_ff;
    nxt_mack = mack_ff;
    nxt_rd_req = 1'b0;
    nxt_pend = pend_ff & ~push;
    nxt_pend_word = pend_word_ff;
    nxt_prog_cnt = prog_cnt_ff;
    case (state_ff)
      ST_IDLE:
      begin
        nxt_oe = 1'b0;
        if (start_det) // see [RULE2]
        begin
          nxt_state = ST_SEL;
          nxt_cnt = `MES_CNT_ZERO;
          nxt_ack_ph = 1'b0;
        end
      end
      ST_PROG:
      begin
        // Bus ignored until the program cycle is over
        nxt_oe = 1'b0; // see [RULE16]
        nxt_prog_cnt = prog_cnt_ff - `MES_PROG_ONE;
        if (prog_cnt_ff <= `MES_PROG_ONE)
        begin
          nxt_state = ST_IDLE; // see [RULE16]
          nxt_prog_cnt = `MES_PROG_ZERO;
        end
      end
      ST_WAIT:
      begin
        nxt_oe = 1'b0; // see [RULE9]
      end
      default:
      begin
        if (scl_rise && !ack_ph_ff)
        begin
          if (cnt_ff != `MES_CNT_BYTE)
          begin
            nxt_cnt = cnt_ff + `MES_CNT_ONE;
            if (state_ff != ST_RD)
            begin
              nxt_shift = {shift_ff[6:0], sda_s_ff}; // see [RULE10]
            end
          end
        end
        if (scl_rise && ack_ph_ff && (state_ff == ST_RD))
        begin
          nxt_mack = ~sda_s_ff; // see [RULE8]
        end
        if (scl_fall && !ack_ph_ff && (cnt_ff == `MES_CNT_BYTE))
        begin
          // Byte complete: decide the ninth bit
          nxt_ack_ph = 1'b1;
          case (state_ff)
            ST_SEL:
            begin
              if (sel_match)
              begin
                nxt_oe = 1'b1; // see [RULE6]
                nxt_psel = id_prot;
                if (shift_ff[`MES_RW_BIT]) // see [RULE14]
                begin
                  nxt_nstate = ST_RD;
                  nxt_rd_req = ~id_prot;
                end
                else if (id_prot)
                begin
                  nxt_nstate = ST_WR;
                end
                else
                begin
                  nxt_nstate = ST_ADDR; // see [RULE13]
                end
              end
              else
              begin
                nxt_oe = 1'b0;
                nxt_ack_ph = 1'b0;
                nxt_state = ST_WAIT;
              end
            end
            ST_ADDR:
            begin
              nxt_oe = 1'b1; // see [RULE7]
              nxt_addr = shift_ff;
              nxt_nstate = ST_WR;
            end
            ST_WR:
            begin
              if (wr_ok)
              begin
                nxt_oe = 1'b1; // see [RULE7]
                nxt_nstate = ST_WR;
                nxt_wr_seen = 1'b1;
                if (psel_ff)
                begin
                  nxt_prot = 1'b1;
                end
                else
                begin
                  nxt_pend = 1'b1;
                  nxt_pend_word = {addr_ff, shift_ff};
                  // Page rolls over within sixteen bytes
                  nxt_addr = {addr_ff[7:4],
                    addr_ff[3:0] + `MES_PAGE_ONE}; // see [RULE15]
                end
              end
              else
              begin
                nxt_oe = 1'b0;
                nxt_ack_ph = 1'b0;
                nxt_state = ST_WAIT;
              end
            end
            default:
            begin
              nxt_oe = 1'b0; // see [RULE5]
              nxt_mack = 1'b0;
              nxt_nstate = ST_RD;
              nxt_rd_req = ~psel_ff;
            end
          endcase
        end
        else if (scl_fall && ack_ph_ff)
        begin
          // Ninth clock over
          nxt_ack_ph = 1'b0;
          nxt_cnt = `MES_CNT_ZERO;
          if (nstate_ff == ST_RD)
          begin
            if ((state_ff == ST_RD) && !mack_ff)
            begin
              nxt_oe = 1'b0; // see [RULE9]
              nxt_state = ST_WAIT;
            end
            else
            begin
              nxt_state = ST_RD; // see [RULE8]
              nxt_shift = tx_byte;
              nxt_oe = ~tx_byte[7]; // see [RULE1]
              if (!psel_ff)
              begin
                nxt_addr = addr_ff + `MES_ADDR_ONE;
              end
            end
          end
          else
          begin
            nxt_oe = 1'b0; // see [RULE5]
            nxt_state = nstate_ff;
          end
        end
        else if (scl_fall && (state_ff == ST_RD) &&
          (cnt_ff != `MES_CNT_ZERO) && !ack_ph_ff)
        begin
          nxt_shift = {shift_ff[6:0], 1'b0};
          nxt_oe = ~shift_ff[6]; // see [RULE1]
        end
      end
    endcase
    if (active && stop_det)
    begin
      nxt_oe = 1'b0;
      nxt_ack_ph = 1'b0;
      nxt_wr_seen = 1'b0;
      nxt_prog_cnt = PROG_CYCLES;
      nxt_state = wr_seen_ff ? ST_PROG : ST_IDLE; // see [RULE4]
    end
    else if (active && start_det)
    begin
      // Repeated start
      nxt_oe = 1'b0;
      nxt_ack_ph = 1'b0;
      nxt_cnt = `MES_CNT_ZERO;
      nxt_state = ST_SEL; // see [RULE13]
    end
  end

  always @(posedge clk_sys)
  begin
    scl_m_ff <= scl_in;
    sda_m_ff <= sda_in;
    cs_m_ff <= {chip_select_bit_2, chip_select_bit_1, chip_select_bit_0};
    wc_m_ff <= write_control_input;
    if (sys_rst)
    begin
      scl_s_ff <= 1'b1;
      scl_d_ff <= 1'b1;
      sda_s_ff <= 1'b1;
      sda_d_ff <= 1'b1;
      cs_s_ff <= 3'h0;
      wc_s_ff <= 1'b1;
      state_ff <= ST_IDLE;
      nstate_ff <= ST_IDLE;
      cnt_ff <= `MES_CNT_ZERO;
      ack_ph_ff <= 1'b0;
      shift_ff <= 8'h00;
      addr_ff <= 8'h00;
      psel_ff <= 1'b0;
      wr_seen_ff <= 1'b0;
      mack_ff <= 1'b0;
      rd_req_ff <= 1'b0;
      pend_ff <= 1'b0;
      pend_word_ff <= 16'h0000;
      prog_cnt_ff <= `MES_PROG_ZERO;
      fifo_wp_ff <= 1'b0;
      fifo_rp_ff <= 1'b0;
      fifo_cnt_ff <= `MES_FIFO_EMPTY;
      sda_out_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      standby_ff <= 1'b1;
      prog_busy_ff <= 1'b0;
      write_protect_ff <= 1'b0;
    end
    else
    begin
      scl_s_ff <= scl_m_ff;
      scl_d_ff <= scl_s_ff;
      sda_s_ff <= sda_m_ff;
      sda_d_ff <= sda_s_ff;
      cs_s_ff <= cs_m_ff;
      wc_s_ff <= wc_m_ff;
      state_ff <= nxt_state;
      nstate_ff <= nxt_nstate;
      cnt_ff <= nxt_cnt;
      ack_ph_ff <= nxt_ack_ph;
      shift_ff <= nxt_shift;
      addr_ff <= nxt_addr;
      psel_ff <= nxt_psel;
      wr_seen_ff <= nxt_wr_seen;
      mack_ff <= nxt_mack;
      rd_req_ff <= nxt_rd_req;
      pend_ff <= nxt_pend;
      pend_word_ff <= nxt_pend_word;
      prog_cnt_ff <= nxt_prog_cnt;
      if (push)
      begin
        fifo_ff[fifo_wp_ff] <= pend_word_ff;
        fifo_wp_ff <= ~fifo_wp_ff;
      end
      if (pop)
      begin
        fifo_rp_ff <= ~fifo_rp_ff;
      end
      if (push && !pop)
      begin
        fifo_cnt_ff <= fifo_cnt_ff + `MES_FIFO_ONE;
      end
      else if (pop && !push)
      begin
        fifo_cnt_ff <= fifo_cnt_ff - `MES_FIFO_ONE;
      end
      sda_out_ff <= 1'b0;
      sda_oe_ff <= nxt_oe;
      standby_ff <= (nxt_state == ST_IDLE); // see [RULE4]
      prog_busy_ff <= (nxt_state == ST_PROG); // see [RULE16]
      write_protect_ff <= nxt_prot;
    end
  end
endmodule // mes_eeprom_slave
`default_nettype wire

// >>> logic/mes_mem.v
`timescale 1ns/1ps
`default_nettype none
`include "mes_regs.vh"
module mes_mem
(
  input wire clk_sys,
  input wire wr_en,
  input wire [`MES_AW-1:0] wr_addr,
  input wire [`MES_DW-1:0] wr_data,
  input wire rd_en,
  input wire [`MES_AW-1:0] rd_addr,
  output reg [`MES_DW-1:0] rd_data_ff
);
  reg [`MES_DW-1:0] mem_ff [0:`MES_DEPTH-1];

  // Separate write and read ports, registered read
  always @(posedge clk_sys)
  begin
    if (wr_en)
    begin
      mem_ff[wr_addr] <= wr_data;
    end
    if (rd_en)
    begin
      rd_data_ff <= mem_ff[rd_addr];
    end
  end
endmodule // mes_mem
`default_nettype wire

// >>> logic/mes_regs.vh
`ifndef MES_REGS_VH
`define MES_REGS_VH
// Select byte fields
`define MES_ID_MSB 7
`define MES_ID_LSB 4
`define MES_CS_MSB 3
`define MES_CS_LSB 1
`define MES_RW_BIT 0
`define MES_ID_MEM 4'hA
`define MES_ID_PROT 4'h6
// Array and buffer shape
`define MES_AW 8
`define MES_DW 8
`define MES_DEPTH 256
`define MES_WW 16
// Bit counting
`define MES_CNT_ZERO 4'h0
`define MES_CNT_ONE 4'h1
`define MES_CNT_BYTE 4'h8
`define MES_ADDR_ONE 8'h01
`define MES_PAGE_ONE 4'h1
`define MES_PROT_PAD 7'h00
`define MES_FIFO_EMPTY 2'h0
`define MES_FIFO_ONE 2'h1
`define MES_FIFO_FULL 2'h2
// Timing
// Program cycle, 10 ms of a 100 MHz clock
`define MES_PROG_CYCLES 20'hF4240
`define MES_PROG_ONE 20'h00001
`define MES_PROG_ZERO 20'h00000
`endif

// >>> tb/mes_eeprom_slave_tb.sv
`timescale 1ns/1ps
`default_nettype none
module mes_eeprom_slave_tb;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [2:0] cs = 3'h0;
  logic wc = 1'b0;
  wire logic scl;
  wire logic m_sda;
  wire logic sda_out;
  wire logic sda_oe;
  wire logic standby;
  wire logic busy;
  wire logic wp;
  wire logic sda = m_sda & ~(sda_oe & ~sda_out);
  int fail_count = 0;
  int comparisons = 0;
  logic [7:0] mem [int];
  logic a;
  logic [7:0] d;
  logic [7:0] base;
  logic [7:0] sel;
  logic [7:0] cur;
  always #5 clk_sys = ~clk_sys;
  mes_eeprom_slave #(.PROG_CYCLES(20'h00032)) u_mes_eeprom_slave (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda),
    .chip_select_bit_2(cs[2]), .chip_select_bit_1(cs[1]),
    .chip_select_bit_0(cs[0]), .write_control_input(wc),
    .sda_out_ff(sda_out), .sda_oe_ff(sda_oe), .standby_ff(standby),
    .prog_busy_ff(busy), .write_protect_ff(wp));
  mes_master u_mes_master (.clk_sys(clk_sys), .sda_in(sda), .scl(scl),
    .sda_drv(m_sda));
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e)
    begin
      fail_count++;
      $display("[ERR] %0t got %0h exp %0h", $time, g, e);
    end
  endtask
  task automatic stop_test();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic tx(input logic [7:0] v, input logic e);
    u_mes_master.send(v, a);
    chk({7'h00, a}, {7'h00, e});
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 400)
    begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 400)
    begin
      fail_count++;
      $display("[ERR] %0t busy stuck got %0h exp %0h", $time, busy, 1'b0);
      stop_test();
    end
    repeat (4) @(posedge clk_sys);
  endtask
  // Select, address, n data bytes with page wrap, stop
  task automatic wr(input logic [7:0] s, input logic [7:0] ad, input int n,
    input logic ok);
    u_mes_master.sta();
    tx(s, 1'b1);
    tx(ad, 1'b1);
    for (int i = 0; i < n; i++)
    begin
      d = 8'($urandom);
      tx(d, ok);
      if (ok && !s[6])
        mem[{ad[7:4], ad[3:0] + i[3:0]}] = d;
    end
    u_mes_master.sto();
  endtask
  // Random read of n bytes, last one refused
  task automatic rd(input logic [7:0] s, input logic [7:0] ad, input int n);
    u_mes_master.sta();
    tx(s, 1'b1);
    tx(ad, 1'b1);
    u_mes_master.sta();
    tx(s | 8'h01, 1'b1);
    for (int i = 0; i < n; i++)
    begin
      u_mes_master.recv(i < n - 1, d);
      chk(d, s[6] ? 8'h01 : mem[ad + i[7:0]]);
    end
    if (!s[6])
      cur = ad + n[7:0];
    repeat (6) @(posedge clk_sys);
    chk({7'h00, sda_oe}, 8'h00);
    u_mes_master.sto();
    wait_idle();
  endtask
  initial
  begin
    void'($urandom(23));
    @(posedge clk_sys);
    cs <= 3'($urandom);
    repeat (7) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    chk({5'h00, standby, busy, wp}, 8'h04);
    sel = {4'hA, cs, 1'b0};
    base = {4'($urandom), 4'hE};
    wr(sel, base, 3, 1'b1);
    repeat (6) @(posedge clk_sys);
    chk({6'h00, standby, busy}, 8'h01);
    u_mes_master.sta();
    tx(sel, 1'b0);
    u_mes_master.sto();
    wait_idle();
    chk({7'h00, standby}, 8'h01);
    rd(sel, base, 2);
    rd(sel, {base[7:4], 4'h0}, 1);
    for (int k = 1; k < 8; k++)
    begin
      u_mes_master.sta();
      tx({4'hA, cs ^ k[2:0], k[0]}, 1'b0);
      u_mes_master.sta();
      tx({4'(2 * k + 1), cs, 1'b0}, 1'b0);
      u_mes_master.sto();
      repeat (8) @(posedge clk_sys);
      chk({7'h00, standby}, 8'h01);
    end
    wc <= 1'b1;
    wr(sel, base, 1, 1'b0);
    wc <= 1'b0;
    wait_idle();
    rd(sel, base, 1);
    // Current address read continues after the last byte sent
    u_mes_master.sta();
    tx(sel | 8'h01, 1'b1);
    u_mes_master.recv(1'b0, d);
    chk(d, mem[cur]);
    u_mes_master.sto();
    wait_idle();
    wr({4'h6, cs, 1'b0}, 8'h00, 1, 1'b1);
    wait_idle();
    chk({7'h00, wp}, 8'h01);
    rd({4'h6, cs, 1'b0}, 8'h00, 2);
    stop_test();
  end
endmodule // mes_eeprom_slave_tb
`default_nettype wire

// >>> tb/mes_master.sv
`timescale 1ns/1ps
`default_nettype none
module mes_master
(
  input wire logic clk_sys,
  input wire logic sda_in,
  output var logic scl,
  output var logic sda_drv
);
  logic r;
  initial
  begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // One bit: data set while low, sampled at end of high
  task automatic bit_io(input logic b, output logic s);
    sda_drv <= b;
    repeat (4) @(posedge clk_sys);
    scl <= 1'b1;
    repeat (3) @(posedge clk_sys);
    s = sda_in;
    scl <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic sta();
    sda_drv <= 1'b1;
    repeat (3) @(posedge clk_sys);
    scl <= 1'b1;
    repeat (4) @(posedge clk_sys);
    sda_drv <= 1'b0;
    repeat (4) @(posedge clk_sys);
    scl <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic sto();
    sda_drv <= 1'b0;
    repeat (3) @(posedge clk_sys);
    scl <= 1'b1;
    repeat (4) @(posedge clk_sys);
    sda_drv <= 1'b1;
    repeat (4) @(posedge clk_sys);
  endtask
  // Top bit first, line released for the answer
  task automatic send(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  task automatic recv(input logic ack, output logic [7:0] d);
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, d[i]);
    bit_io(~ack, r);
  endtask
endmodule // mes_master
`default_nettype wire

// >>> tb/mes_slave_properties.sv
`timescale 1ns/1ps
`default_nettype none
module mes_slave_props
#(
  parameter int PROG_CYCLES = 50
)
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic chip_select_bit_2,
  input wire logic chip_select_bit_1,
  input wire logic chip_select_bit_0,
  input wire logic write_control_input,
  input wire logic sda_out_ff,
  input wire logic sda_oe_ff,
  input wire logic standby_ff,
  input wire logic prog_busy_ff,
  input wire logic write_protect_ff
);
  logic scl_dly_ff;
  logic sda_dly_ff;
  int busy_cnt_ff;
  int since_stop_ff;
  wire logic stop_ev = scl_in & scl_dly_ff & sda_in & ~sda_dly_ff;
  // Pin history and busy length
  always @(posedge clk_sys)
  begin
    scl_dly_ff <= scl_in;
    sda_dly_ff <= sda_in;
    busy_cnt_ff <= (sys_rst || !prog_busy_ff) ? 0 : busy_cnt_ff + 1;
    since_stop_ff <= (sys_rst || stop_ev) ? 0 : since_stop_ff + 1;
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  out_low_a: assert property (sda_out_ff == 1'b0)
    else $error("data output not low");
  oe_edge_low_a: assert property ($changed(sda_oe_ff) |-> !scl_in)
    else $error("data drive moved with clock high");
  oe_hold_a: assert property ($rose(sda_oe_ff) |=> sda_oe_ff [*6])
    else $error("driven bit too short");
  idle_quiet_a: assert property (standby_ff |-> !sda_oe_ff)
    else $error("drive while idle");
  busy_quiet_a: assert property (prog_busy_ff |-> !sda_oe_ff)
    else $error("drive while programming");
  mode_excl_a: assert property (!(standby_ff && prog_busy_ff))
    else $error("idle and busy together");
  stop_idle_a: assert property (stop_ev |-> ##[1:6]
    (standby_ff || prog_busy_ff))
    else $error("stop not followed by idle");
  busy_cause_a: assert property ($rose(prog_busy_ff) |->
    since_stop_ff <= 8)
    else $error("program cycle without stop");
  busy_len_a: assert property ($fell(prog_busy_ff) |->
    busy_cnt_ff >= PROG_CYCLES - 2 && busy_cnt_ff <= PROG_CYCLES + 2)
    else $error("program cycle length wrong");
  cover property ($rose(prog_busy_ff));
  cover property ($rose(write_protect_ff));
  cover property ($rose(sda_oe_ff));
endmodule // mes_slave_props
bind mes_eeprom_slave mes_slave_props #(.PROG_CYCLES(PROG_CYCLES)) u_props (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .scl_in(scl_in), .sda_in(sda_in),
  .chip_select_bit_2(chip_select_bit_2),
  .chip_select_bit_1(chip_select_bit_1),
  .chip_select_bit_0(chip_select_bit_0),
  .write_control_input(write_control_input), .sda_out_ff(sda_out_ff),
  .sda_oe_ff(sda_oe_ff), .standby_ff(standby_ff),
  .prog_busy_ff(prog_busy_ff), .write_protect_ff(write_protect_ff)
);
`default_nettype wire
